// [common/lsdp_pkg.sv]
// Package with types and constants for the load-store data port.
package lsdp_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned MAX_OUTSTANDING = 2;
  localparam logic [1:0] OUTS_LIMIT = 2'h2;

  // Access sizes.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [1:0] WORD_LAST_BYTE = 2'h3;
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hf;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] WORD_MASK = 32'hffff_fffc;

  // Request from the core side.
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] offset;
    logic post_inc;
    logic we;
    logic [1:0] size;
    logic sign_ext;
    logic [31:0] wdata;
  } lsdp_cmd_t;

  // Result returned to the core side.
  typedef struct packed {
    logic [31:0] rdata;
    logic [31:0] new_base;
    logic we;
  } lsdp_rsp_t;

  // One bus transaction held in the issue buffer.
  typedef struct packed {
    logic [31:0] addr;
    logic we;
    logic [3:0] be;
    logic [31:0] wdata;
  } lsdp_bus_req_t;

  // Tracking record for a granted transaction.
  typedef struct packed {
    logic we;
    logic [1:0] size;
    logic sign_ext;
    logic [1:0] lane;
    logic split_first;
    logic split_second;
    logic [31:0] new_base;
  } lsdp_track_t;

endpackage

// [core/lsdp_skid2.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module lsdp_skid2 #(
  parameter int unsigned WIDTH = 32
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; entries are only read while counted valid.
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule

// [core/lsdp_track_fifo.sv]
// Two-entry in-order tracker for granted bus transactions.
`timescale 1ns/1ps
module lsdp_track_fifo
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic push,
  input wire lsdp_pkg::lsdp_track_t push_data,
  input wire logic pop,
  output lsdp_pkg::lsdp_track_t head,
  output logic [1:0] count
);

  lsdp_pkg::lsdp_track_t mem [2];
  logic rd_ptr;
  logic wr_ptr;

  assign head = mem[rd_ptr];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= push_data;
  end

endmodule

// [core/lsdp_load_store_unit.sv]
// Load-store data port: splits accesses and drives the request/grant/valid bus.
// Contract
// (R1) Supports byte, halfword and word loads and stores.
// (R2) At most two granted but unanswered transactions; no deeper queue.
// (R3) Request-valid stays high until grant is seen high.
// (R4) Address-phase outputs hold steady until granted.
// (R5) Write enable high for stores, low for loads, with request-valid.
// (R6) Byte enables mark exactly the lanes accessed, with request-valid.
// (R7) Store data presented with request-valid and held until granted.
// (R8) Memory gives exactly one response-valid per granted transaction.
// (R9) Load data captured when response-valid is high; ignored for stores.
// (R10) No misaligned-address exception is ever raised.
// (R11) Word-boundary-crossing accesses become two bus transactions.
// (R12) The lower-address transaction of a split is issued first.
// (R13) Accesses within one word use a single bus transaction.
// (R14) Optional bus signals are omitted, as if tied to defaults.
// (R15) Memory returns responses in grant order, one per request.
// (R16) Grant may be high before any request is presented.
// (R17) Response comes no earlier than the cycle after grant.
// (R18) Post-increment uses the base address and returns base plus offset.
// (R19) Sub-words placed on and taken from lanes by address; splits reassembled.
`timescale 1ns/1ps
module lsdp_load_store_unit #(
  parameter bit custom_ext_enable_param = 1'b0
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire lsdp_pkg::lsdp_cmd_t cmd,
  output logic rsp_valid,
  output lsdp_pkg::lsdp_rsp_t rsp,
  output logic mem_req, // R14
  input wire logic mem_gnt,
  output logic [31:0] mem_addr,
  output logic mem_we,
  output logic [3:0] mem_byte_en_out,
  output logic [31:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata
);

  // ----------------------------------------------------------------
  // Address generation and split decode
  // ----------------------------------------------------------------

  function automatic logic [3:0] size_be(input logic [1:0] size);
    case (size)
      lsdp_pkg::SIZE_BYTE: size_be = lsdp_pkg::BE_BYTE;
      lsdp_pkg::SIZE_HALF: size_be = lsdp_pkg::BE_HALF;
      default: size_be = lsdp_pkg::BE_WORD;
    endcase
  endfunction

  typedef enum logic [1:0] {
    LSDP_ST_FIRST = 2'b01,
    LSDP_ST_SECOND = 2'b10
  } lsdp_issue_st_t;

  lsdp_issue_st_t state;
  lsdp_issue_st_t next_state;
  lsdp_pkg::lsdp_bus_req_t held_req;
  lsdp_pkg::lsdp_track_t held_trk;

  // Post-increment addresses memory with the bare base; otherwise base plus offset.
  wire use_base = custom_ext_enable_param && cmd.post_inc; // R18
  wire [31:0] eff_addr = use_base ? cmd.base : cmd.base + cmd.offset; // R18
  wire [31:0] new_base = cmd.base + cmd.offset; // R18
  wire [1:0] lane = eff_addr[1:0];
  wire [7:0] be_wide = {4'h0, size_be(cmd.size)} << lane; // R6
  wire crosses = (be_wide[7:4] != 4'h0); // R10 R11 R13
  wire [63:0] wd_wide = {32'h0000_0000, cmd.wdata} << {lane, 3'h0}; // R19

  // Two bus transactions for one split access; the lower word goes first.
  lsdp_pkg::lsdp_bus_req_t first_req;
  lsdp_pkg::lsdp_bus_req_t second_req;
  lsdp_pkg::lsdp_track_t first_trk;
  lsdp_pkg::lsdp_track_t second_trk;
  lsdp_pkg::lsdp_bus_req_t pend_req;
  lsdp_pkg::lsdp_track_t pend_trk;

  assign first_req = '{addr: eff_addr, we: cmd.we, be: be_wide[3:0],
                       wdata: wd_wide[31:0]}; // R12 R19
  assign second_req = '{addr: (eff_addr & lsdp_pkg::WORD_MASK) + lsdp_pkg::WORD_STEP,
                        we: cmd.we, be: be_wide[7:4], wdata: wd_wide[63:32]}; // R11
  assign first_trk = '{we: cmd.we, size: cmd.size, sign_ext: cmd.sign_ext, lane: lane,
                       split_first: crosses, split_second: 1'b0, new_base: new_base};
  assign second_trk = '{we: cmd.we, size: cmd.size, sign_ext: cmd.sign_ext, lane: lane,
                        split_first: 1'b0, split_second: 1'b1, new_base: new_base};

  // ----------------------------------------------------------------
  // Issue path through the two-entry buffer
  // ----------------------------------------------------------------

  wire buf_in_ready;
  wire buf_out_valid;
  wire [$bits(lsdp_pkg::lsdp_bus_req_t)+$bits(lsdp_pkg::lsdp_track_t)-1:0] buf_out;
  lsdp_pkg::lsdp_bus_req_t bus_head;
  lsdp_pkg::lsdp_track_t bus_trk;
  wire [1:0] outs;
  lsdp_pkg::lsdp_track_t trk_head;

  // The upper half is captured with the command, so the core may move on at once.
  always_comb
  begin
    pend_req = first_req;
    pend_trk = first_trk;
    if (state == LSDP_ST_SECOND)
    begin
      pend_req = held_req; // R12
      pend_trk = held_trk;
    end
  end

  wire push_first = (state == LSDP_ST_FIRST) && cmd_valid && buf_in_ready;
  wire push_second = (state == LSDP_ST_SECOND) && buf_in_ready;
  wire buf_push = push_first || push_second;
  assign cmd_ready = (state == LSDP_ST_FIRST) && buf_in_ready;

  always_comb
  begin
    next_state = state;
    case (state)
      LSDP_ST_FIRST: if (push_first && crosses) next_state = LSDP_ST_SECOND; // R11
      LSDP_ST_SECOND: if (push_second) next_state = LSDP_ST_FIRST;
      default: next_state = LSDP_ST_FIRST;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= LSDP_ST_FIRST;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk)
  begin
    if (push_first)
    begin
      held_req <= second_req; // R11
      held_trk <= second_trk;
    end
  end

  // Holding the head in the buffer keeps address-phase outputs steady until grant.
  wire grant_ok = (outs < lsdp_pkg::OUTS_LIMIT); // R2
  wire granted = mem_req && mem_gnt; // R3
  lsdp_skid2 #(
    .WIDTH($bits(lsdp_pkg::lsdp_bus_req_t) + $bits(lsdp_pkg::lsdp_track_t))
  ) u_issue_buf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data({pend_req, pend_trk}),
    .out_valid(buf_out_valid),
    .out_ready(granted),
    .out_data(buf_out)
  );

  assign {bus_head, bus_trk} = buf_out;

  // Request drops only on a slot limit seen before it rose; once raised, a held
  // request cannot be withdrawn because outs only falls while it waits.
  logic req_up;
  assign mem_req = buf_out_valid && (grant_ok || req_up); // R2 R3
  assign mem_addr = bus_head.addr; // R4
  assign mem_we = bus_head.we; // R5
  assign mem_byte_en_out = bus_head.be; // R6
  assign mem_wdata = bus_head.wdata; // R7

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      req_up <= 1'b0;
    else
      req_up <= mem_req && !mem_gnt; // R3
  end

  // ----------------------------------------------------------------
  // Response tracking and load data assembly
  // ----------------------------------------------------------------

  // Responses are matched in grant order since the bus carries no identifier.
  lsdp_track_fifo u_track (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .push(granted),
    .push_data(bus_trk),
    .pop(mem_rvalid), // R8 R15
    .head(trk_head),
    .count(outs)
  );

  logic [31:0] low_part;
  wire [63:0] joined = trk_head.split_second ? {mem_rdata, low_part}
                       : {32'h0000_0000, mem_rdata}; // R19
  wire [63:0] shifted = joined >> {trk_head.lane, 3'h0}; // R19
  logic [31:0] extracted;

  always_comb
  begin
    case (trk_head.size)
      lsdp_pkg::SIZE_BYTE:
        extracted = {{24{trk_head.sign_ext & shifted[7]}}, shifted[7:0]};
      lsdp_pkg::SIZE_HALF:
        extracted = {{16{trk_head.sign_ext & shifted[15]}}, shifted[15:0]};
      default:
        extracted = shifted[31:0];
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (mem_rvalid && trk_head.split_first)
      low_part <= mem_rdata; // R9
  end

  // A split access answers once, on the response of its upper half.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      rsp_valid <= mem_rvalid && !trk_head.split_first;
      if (mem_rvalid && !trk_head.split_first)
      begin
        rsp.rdata <= trk_head.we ? 32'h0000_0000 : extracted; // R9 R1
        rsp.new_base <= trk_head.new_base; // R18
        rsp.we <= trk_head.we;
      end
    end
  end

endmodule

// [sim/lsdp_assertions.sv]
// Checker for the bus rules of the load-store data port.
`timescale 1ns/1ps
module lsdp_chk
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic mem_gnt,
  input wire logic [31:0] mem_addr,
  input wire logic mem_we,
  input wire logic [3:0] mem_byte_en_out,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic rsp_valid
);
  logic [2:0] outs;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      outs <= 3'h0;
    else
      outs <= outs + 3'(mem_req && mem_gnt) - 3'(mem_rvalid);
  end
  sequence s_wait;
    mem_req && !mem_gnt;
  endsequence
  property p_req;
    s_wait |=> mem_req;
  endproperty
  a_req: assert property (p_req) else $error("req dropped");
  property p_addr;
    s_wait |=> $stable(mem_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
  property p_we;
    s_wait |=> $stable(mem_we);
  endproperty
  a_we: assert property (p_we) else $error("we moved");
  property p_be;
    s_wait |=> $stable(mem_byte_en_out);
  endproperty
  a_be: assert property (p_be) else $error("be moved");
  property p_wdata;
    s_wait |=> $stable(mem_wdata);
  endproperty
  a_wdata: assert property (p_wdata) else $error("wdata moved");
  property p_outs;
    outs <= 3'h2;
  endproperty
  a_outs: assert property (p_outs) else $error("over two in flight");
  property p_lanes;
    mem_req |-> mem_byte_en_out[mem_addr[1:0]]
      && (mem_byte_en_out & ((4'h1 << mem_addr[1:0]) - 4'h1)) == 4'h0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lanes off address");
  property p_rsp;
    rsp_valid |-> $past(mem_rvalid);
  endproperty
  a_rsp: assert property (p_rsp) else $error("answer without response");
endmodule
bind lsdp_load_store_unit lsdp_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .mem_req(mem_req), .mem_gnt(mem_gnt), .mem_addr(mem_addr), .mem_we(mem_we),
  .mem_byte_en_out(mem_byte_en_out), .mem_wdata(mem_wdata),
  .mem_rvalid(mem_rvalid), .rsp_valid(rsp_valid));

// [sim/lsdp_mem_model.sv]
// Data memory model on the far side of the port.
`timescale 1ns/1ps
module lsdp_mem_model
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic mem_req,
  output logic mem_gnt,
  input wire logic [31:0] mem_addr,
  input wire logic mem_we,
  input wire logic [3:0] mem_byte_en_out,
  input wire logic [31:0] mem_wdata,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] ram [0:15];
  logic [31:0] q [$];
  initial
  begin
    mem_gnt = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata = 32'h0000_0000;
  end
  // Data is taken at grant, so a later store never leaks into an older load.
  always @(posedge mclk)
  begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    mem_gnt <= !slow || $urandom_range(1);
    if (sys_rst)
      q.delete();
    else
    begin
      if (q.size() != 0 && (!slow || $urandom_range(1)))
      begin
        mem_rvalid <= 1'b1;
        mem_rdata <= q.pop_front();
      end
      if (mem_req && mem_gnt)
      begin
        q.push_back(mem_we ? $urandom : ram[mem_addr[5:2]]);
        for (int k = 0; k < 4; k++)
          if (mem_we && mem_byte_en_out[k])
            ram[mem_addr[5:2]][8*k+:8] <= mem_wdata[8*k+:8];
      end
    end
  end
endmodule

// [sim/testbench.sv]
// Self-checking testbench for the load-store data port.
`timescale 1ns/1ps
module testbench;
  logic mclk;
  logic sys_rst;
  logic cmd_valid;
  logic cmd_ready;
  lsdp_pkg::lsdp_cmd_t cmd;
  logic rsp_valid;
  lsdp_pkg::lsdp_rsp_t rsp;
  logic mem_req;
  logic mem_gnt;
  logic [31:0] mem_addr;
  logic mem_we;
  logic [3:0] mem_byte_en_out;
  logic [31:0] mem_wdata;
  logic mem_rvalid;
  logic [31:0] mem_rdata;
  logic slow;
  logic [31:0] w;
  logic [7:0] img [0:63];
  logic [31:0] ga [$];
  logic [3:0] gb [$];
  logic gw [$];
  int failures;
  int compares;
  lsdp_load_store_unit #(.custom_ext_enable_param(1'b1)) uut (.mclk(mclk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .mem_req(mem_req), .mem_gnt(mem_gnt),
    .mem_addr(mem_addr), .mem_we(mem_we), .mem_byte_en_out(mem_byte_en_out),
    .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  lsdp_mem_model mem (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .mem_req(mem_req),
    .mem_gnt(mem_gnt), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_byte_en_out(mem_byte_en_out), .mem_wdata(mem_wdata),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  always #5 mclk = ~mclk;
  always @(posedge mclk)
    if (mem_req && mem_gnt)
    begin
      ga.push_back(mem_addr);
      gb.push_back(mem_byte_en_out);
      gw.push_back(mem_we);
    end
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_hi(input logic want_rsp);
    int i;
    for (i = 0; i < 100 && (want_rsp ? rsp_valid : cmd_ready) !== 1'b1; i++)
      tick();
    if (i == 100)
    begin
      failures++;
      $display("BAD wait expected 1 seen 0");
      stop_test();
    end
  endtask
  function automatic logic [31:0] ld(input logic [5:0] a, input logic [1:0] sz,
    input logic sx);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int k = 0; k < (1 << sz); k++)
      r[8*k+:8] = img[6'(a + k)];
    if (sx && sz == lsdp_pkg::SIZE_BYTE)
      r = {{24{r[7]}}, r[7:0]};
    if (sx && sz == lsdp_pkg::SIZE_HALF)
      r = {{16{r[15]}}, r[15:0]};
    return r;
  endfunction
  task automatic op(input logic [31:0] b, input logic [31:0] o, input logic pi,
    input logic we, input logic [1:0] sz, input logic sx);
    logic [5:0] ea;
    logic [31:0] wd;
    logic [7:0] m;
    logic sp;
    ea = pi ? b[5:0] : 6'(b + o);
    wd = $urandom;
    m = {4'h0, sz == lsdp_pkg::SIZE_BYTE ? lsdp_pkg::BE_BYTE :
      sz == lsdp_pkg::SIZE_HALF ? lsdp_pkg::BE_HALF : lsdp_pkg::BE_WORD} << ea[1:0];
    sp = m[7:4] != 4'h0;
    ga.delete();
    gb.delete();
    gw.delete();
    cmd = lsdp_pkg::lsdp_cmd_t'{b, o, pi, we, sz, sx, wd};
    cmd_valid = 1'b1;
    wait_hi(1'b0);
    tick();
    cmd_valid = 1'b0;
    wait_hi(1'b1);
    chk("txns", sp ? 2 : 1, 32'(ga.size()));
    chk("addr0", 32'(ea), ga[0]);
    chk("be0", 32'(m[3:0]), 32'(gb[0]));
    chk("we0", 32'(we), 32'(gw[0]));
    if (sp)
    begin
      chk("addr1", 32'({ea[5:2], 2'h0}) + 32'h4, ga[1]);
      chk("be1", 32'(m[7:4]), 32'(gb[1]));
    end
    chk("rdata", we ? 32'h0 : ld(ea, sz, sx), rsp.rdata);
    chk("base", b + o, rsp.new_base);
    chk("rwe", 32'(we), 32'(rsp.we));
    for (int k = 0; k < (1 << sz); k++)
      if (we)
        img[6'(ea + k)] = wd[8*k+:8];
  endtask
  // Three word loads from a0 upward issued back to back, split when a0 is not word aligned, so the two-in-flight limit is reached.
  task automatic burst(input logic [5:0] a0);
    logic [31:0] e [3];
    for (int n = 0; n < 3; n++)
      e[n] = ld(6'(a0 + 6'(4 * n)), lsdp_pkg::SIZE_WORD, 1'b0);
    fork
      begin
        for (int n = 0; n < 3; n++)
        begin
          cmd = lsdp_pkg::lsdp_cmd_t'{32'(a0) + 32'(4 * n), 32'h0, 1'b0, 1'b0,
            lsdp_pkg::SIZE_WORD, 1'b0, 32'h0};
          cmd_valid = 1'b1;
          wait_hi(1'b0);
          tick();
        end
        cmd_valid = 1'b0;
      end
      for (int n = 0; n < 3; n++)
      begin
        tick();
        wait_hi(1'b1);
        chk("burst", e[n], rsp.rdata);
      end
    join
  endtask
  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b1;
    failures = 0;
    compares = 0;
    void'($urandom(32'h0883_482f));
    for (int i = 0; i < 16; i++)
    begin
      w = $urandom;
      mem.ram[i] = w;
      for (int k = 0; k < 4; k++)
        img[4*i+k] = w[8*k+:8];
    end
    repeat (20) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    // -------------------------------------------------------------------
    // Word-boundary corners first, then random traffic.
    // -------------------------------------------------------------------
    op(32'h3, 32'h0, 1'b0, 1'b1, 2'h2, 1'b0);
    op(32'h3, 32'h0, 1'b0, 1'b0, 2'h2, 1'b0);
    op(32'h7, 32'h0, 1'b0, 1'b0, 2'h1, 1'b1);
    op(32'h1, 32'h0, 1'b0, 1'b0, 2'h1, 1'b1);
    op(32'h8, 32'h5, 1'b1, 1'b0, 2'h2, 1'b0);
    slow = 1'b0;
    burst(6'h3);
    slow = 1'b1;
    burst(6'($urandom_range(40)));
    for (int s = 0; s < 6; s++)
      op(32'h12, 32'h1, 1'b0, s[0], 2'(s >> 1), 1'b1);
    repeat (80)
    begin
      slow = 1'($urandom_range(1));
      op($urandom_range(48), $urandom_range(8), 1'($urandom_range(1)),
        1'($urandom_range(1)), 2'($urandom_range(2)), 1'($urandom_range(1)));
    end
    stop_test();
  end
endmodule
